/* design/ebp_defs.vh */
// Constants for the enhanced bridge PWM output stage.
// Assumes a 32-bit APB slave and a 25 MHz oscillator clock.
`ifndef EBP_DEFS_VH
`define EBP_DEFS_VH

// Register byte offsets
`define EBP_OFS_CTRL      8'h00
`define EBP_OFS_DUTY      8'h04
`define EBP_OFS_DBAND     8'h08
`define EBP_OFS_PERIOD    8'h0C
`define EBP_OFS_TMRCFG    8'h10
`define EBP_OFS_STATUS    8'h14

// Control register fields
`define EBP_OCFG_HI       7
`define EBP_OCFG_LO       6
`define EBP_DFRAC_HI      5
`define EBP_DFRAC_LO      4
`define EBP_MODE_HI       3
`define EBP_MODE_LO       0
`define EBP_POL_AC        1
`define EBP_POL_BD        0

// Timer configuration fields
`define EBP_CFG_PRE_HI    1
`define EBP_CFG_PRE_LO    0
`define EBP_CFG_TMR_ON    2
`define EBP_CFG_PPORT     3

// Status fields
`define EBP_STAT_RUN      8

// Reset values
`define EBP_RST_CTRL      8'h00
`define EBP_RST_DUTY      8'h00
`define EBP_RST_DBAND     8'h00
`define EBP_RST_PERIOD    8'hFF
`define EBP_RST_TMRCFG    4'h0

// Mode and configuration codes
`define EBP_MODE_PWM      2'b11
`define EBP_OCFG_SINGLE   2'b00
`define EBP_OCFG_FWD      2'b01
`define EBP_OCFG_HALF     2'b10
`define EBP_OCFG_REV      2'b11
`define EBP_PRE_1         2'b00
`define EBP_PRE_4         2'b01

// Timing: one instruction cycle is four oscillator periods
`define EBP_TOSC_PS       40000
`define EBP_CLK_PS        40000
`define EBP_INST_TOSC     4
`define EBP_INST_CYC      ((`EBP_INST_TOSC * `EBP_TOSC_PS) / `EBP_CLK_PS)

`endif

/* design/ebp_presc.v */
// Prescaler for the period timer of the enhanced PWM stage.
// Assumes one clock; produces one-cycle enable pulses, or a steady enable at prescale 1.
`timescale 1ns/1ps
`default_nettype none
`include "ebp_defs.vh"

module ebp_presc (
	input  wire       ref_clk_i,
	input  wire       rst_b_i,
	input  wire       run_i,
	input  wire [1:0] pre_sel_i,
	output wire       fine_tick_o
);

	reg [3:0] cnt_q;

	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 4'h0;
		end else if (!run_i) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// Prescale 1, 4 or 16 oscillator periods per fine step
	assign fine_tick_o = run_i & ((pre_sel_i == `EBP_PRE_1) ? 1'b1 :
		(pre_sel_i == `EBP_PRE_4) ? (cnt_q[1:0] == 2'b11) : (cnt_q == 4'hF));

endmodule // ebp_presc
`default_nettype wire

/* design/ebp_dband.v */
// Dead-band delay on the turn-on edge of one bridge leg.
// Assumes the delay value is stable while the input is high.
`timescale 1ns/1ps
`default_nettype none
`include "ebp_defs.vh"

module ebp_dband #(
	parameter DLY_W = 7
) (
	input  wire             ref_clk_i,
	input  wire             rst_b_i,
	input  wire [DLY_W-1:0] delay_i,
	input  wire             in_i,
	output reg              out_o
);

	reg  [DLY_W+1:0] cnt_q;
	wire [DLY_W+1:0] target;
	wire [31:0]      target_full;

	// Delay counted in oscillator periods, four per step
	assign target_full = delay_i * `EBP_INST_CYC;
	assign target      = target_full[DLY_W+1:0];

	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= {(DLY_W+2){1'b0}};
			out_o <= 1'b0;
		end else if (!in_i) begin
			// Turn-off is never delayed
			cnt_q <= {(DLY_W+2){1'b0}};
			out_o <= 1'b0;
		end else if (cnt_q >= target) begin
			out_o <= 1'b1; // R15 R16
		end else begin
			cnt_q <= cnt_q + {{(DLY_W+1){1'b0}}, 1'b1};
		end
	end

endmodule // ebp_dband
`default_nettype wire

/* design/ebp_pwm.v */
// Enhanced bridge PWM output stage with APB register access.
// Assumes APB master on ref_clk_i; pins are owned only when pwm_own_*_o is high.
//
// Functional notes
// R1 - Non-PWM modes: output A is the capture/compare pin; B, C, D are port pins.
// R2 - PWM mode with config 00: only A modulated; B, C, D are port pins.
// R3 - Config 01 forward: D modulated, A active, B and C inactive.
// R4 - Config 10 half-bridge: A and B complementary with dead band; C, D port pins.
// R5 - Config 11 reverse: B modulated, C active, A and D inactive.
// R6 - Duty is 10 bits: fraction field low two bits, duty-high byte high eight.
// R7 - Four outputs A to D; config and mode bits set mapping and polarity.
// R8 - Control settings double-buffered, copied to active set at period boundary.
// R9 - Dead-band register loaded at duty boundary or period boundary.
// R10 - Output starts only after the period timer resets.
// R11 - Software sets port pin directions to output; module does not.
// R12 - Parallel port enable suppressed while two or four output PWM runs.
// R13 - Period is four oscillator periods times period plus one times prescale.
// R14 - Duty time is oscillator period times 10-bit duty times prescale.
// R15 - Dead band is four oscillator periods times the 7-bit delay value.
// R16 - Half-bridge B complements A; turn-on edges delayed, never both active.
// R17 - Active at period start, inactive at duty match; polarity applied last.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ebp_defs.vh"

module ebp_pwm #(
	parameter DLY_W = 7
) (
	input  wire        ref_clk_i,
	input  wire        rst_b_i,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output reg         pwm_a_o,
	output reg         pwm_b_o,
	output reg         pwm_c_o,
	output reg         pwm_d_o,
	output reg         pwm_own_a_o,
	output reg         pwm_own_b_o,
	output reg         pwm_own_c_o,
	output reg         pwm_own_d_o,
	output reg         pport_en_o
);

	// Software-visible registers
	reg [7:0]       ctrl_q;
	reg [7:0]       duty_q;
	reg [DLY_W-1:0] dband_q;
	reg [7:0]       period_q;
	reg [3:0]       cfg_q;

	// Active copies used by the waveform logic
	reg [1:0]       ocfg_a_q;
	reg [3:0]       mode_a_q;
	reg [9:0]       duty_a_q;
	reg [DLY_W-1:0] dband_a_q;
	reg             run_q;

	// Period timer: eight-bit count plus two-bit fine step
	reg [7:0]       tmr_q;
	reg [1:0]       sub_q;

	wire        fine_tick;
	wire        tmr_on;
	wire        pwm_req;
	wire        period_hit;
	wire        duty_hit;
	wire [9:0]  fine_cnt;
	wire        mod_hi;
	wire        dbl_a;
	wire        dbl_b;
	wire        wr_en;
	wire        rd_setup;
	wire        addr_ok;
	// Control fields and derived values
	wire [1:0]  ctrl_ocfg;
	wire [1:0]  ctrl_dfrac;
	wire [3:0]  ctrl_mode;
	wire [9:0]  duty_next;
	wire [31:0] status_word;
	wire        dband_load;

	assign tmr_on   = cfg_q[`EBP_CFG_TMR_ON];
	assign pwm_req  = (ctrl_q[`EBP_MODE_HI:`EBP_MODE_HI-1] == `EBP_MODE_PWM);
	assign fine_cnt = {tmr_q, sub_q};

	// Control fields as the active copies take them
	assign ctrl_ocfg   = ctrl_q[`EBP_OCFG_HI:`EBP_OCFG_LO];
	assign ctrl_dfrac  = ctrl_q[`EBP_DFRAC_HI:`EBP_DFRAC_LO];
	assign ctrl_mode   = ctrl_q[`EBP_MODE_HI:`EBP_MODE_LO];
	assign duty_next   = {duty_q, ctrl_dfrac};
	assign status_word = {23'h00_0000, run_q, tmr_q};

	// Duty match only counts once PWM runs; the boundary always does
	assign dband_load  = period_hit | (run_q & duty_hit);

	// APB decode: zero wait states, unmapped addresses flagged
	assign addr_ok = (paddr == `EBP_OFS_CTRL) | (paddr == `EBP_OFS_DUTY) |
		(paddr == `EBP_OFS_DBAND) | (paddr == `EBP_OFS_PERIOD) |
		(paddr == `EBP_OFS_TMRCFG) | (paddr == `EBP_OFS_STATUS);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~addr_ok;
	assign wr_en    = psel & penable & pwrite & addr_ok;
	assign rd_setup = psel & ~penable & ~pwrite;

	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q   <= `EBP_RST_CTRL;
			duty_q   <= `EBP_RST_DUTY;
			dband_q  <= {DLY_W{1'b0}};
			period_q <= `EBP_RST_PERIOD;
			cfg_q    <= `EBP_RST_TMRCFG;
		end else if (wr_en) begin
			// Status is read-only: a write there is dropped without error
			if (paddr == `EBP_OFS_CTRL) begin
				ctrl_q <= pwdata[7:0];
			end else if (paddr == `EBP_OFS_DUTY) begin
				duty_q <= pwdata[7:0];
			end else if (paddr == `EBP_OFS_DBAND) begin
				dband_q <= pwdata[DLY_W-1:0];
			end else if (paddr == `EBP_OFS_PERIOD) begin
				period_q <= pwdata[7:0];
			end else if (paddr == `EBP_OFS_TMRCFG) begin
				cfg_q <= pwdata[3:0];
			end
		end
	end

	// Read data captured in the setup cycle, valid through the access cycle
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			if (paddr == `EBP_OFS_CTRL) begin
				prdata <= {24'h00_0000, ctrl_q};
			end else if (paddr == `EBP_OFS_DUTY) begin
				prdata <= {24'h00_0000, duty_q};
			end else if (paddr == `EBP_OFS_DBAND) begin
				prdata <= {{(32-DLY_W){1'b0}}, dband_q};
			end else if (paddr == `EBP_OFS_PERIOD) begin
				prdata <= {24'h00_0000, period_q};
			end else if (paddr == `EBP_OFS_TMRCFG) begin
				prdata <= {28'h000_0000, cfg_q};
			end else if (paddr == `EBP_OFS_STATUS) begin
				// Live timer value: it moves between two reads
				prdata <= status_word;
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	ebp_presc u_presc (
		.ref_clk_i   (ref_clk_i),
		.rst_b_i     (rst_b_i),
		.run_i       (tmr_on),
		.pre_sel_i   (cfg_q[`EBP_CFG_PRE_HI:`EBP_CFG_PRE_LO]),
		.fine_tick_o (fine_tick)
	);

	// Last fine step of the count equal to the period register
	assign period_hit = fine_tick & (tmr_q == period_q) & (sub_q == 2'b11); // R13
	assign duty_hit   = fine_tick & (fine_cnt == duty_a_q);

	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tmr_q <= 8'h00;
			sub_q <= 2'b00;
		end else if (!tmr_on) begin
			// Stopping clears the count, so a restart begins a fresh period
			tmr_q <= 8'h00;
			sub_q <= 2'b00;
		end else if (period_hit) begin
			tmr_q <= 8'h00;
			sub_q <= 2'b00;
		end else if (fine_tick) begin
			sub_q <= sub_q + 2'b01;
			if (sub_q == 2'b11) begin
				tmr_q <= tmr_q + 8'h01;
			end
		end
	end

	// Leaving PWM takes effect at once; entering waits for a timer reset
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ocfg_a_q <= 2'b00;
			mode_a_q <= 4'h0;
			duty_a_q <= 10'h000;
			run_q    <= 1'b0;
		end else if (!pwm_req) begin
			ocfg_a_q <= ctrl_ocfg;
			mode_a_q <= ctrl_mode;
			run_q    <= 1'b0;
		end else if (period_hit) begin
			ocfg_a_q <= ctrl_ocfg; // R8
			mode_a_q <= ctrl_mode; // R7
			duty_a_q <= duty_next; // R6
			run_q    <= 1'b1; // R10
		end
	end

	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dband_a_q <= {DLY_W{1'b0}};
		end else if (dband_load) begin
			dband_a_q <= dband_q; // R9
		end
	end

	// Count below duty means the active part of the period
	assign mod_hi = run_q & (fine_cnt < duty_a_q); // R14 R17

	ebp_dband #(.DLY_W(DLY_W)) u_dband_a (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.delay_i   (dband_a_q),
		.in_i      (mod_hi),
		.out_o     (dbl_a)
	);

	ebp_dband #(.DLY_W(DLY_W)) u_dband_b (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.delay_i   (dband_a_q),
		.in_i      (run_q & ~mod_hi), // R16
		.out_o     (dbl_b)
	);

	// Logical levels before polarity, and pin ownership
	reg [3:0] lvl;
	reg [3:0] own;

	always @* begin
		lvl = 4'h0;
		own = 4'h0;
		if (mode_a_q[3:2] != `EBP_MODE_PWM) begin
			// Capture and compare themselves live outside this stage
			own = {3'b000, mode_a_q != 4'h0}; // R1
		end else if (run_q) begin
			case (ocfg_a_q)
				`EBP_OCFG_SINGLE: begin
					lvl = {3'b000, mod_hi}; // R2
					own = 4'b0001;
				end
				`EBP_OCFG_FWD: begin
					lvl = {mod_hi, 2'b00, 1'b1}; // R3
					own = 4'b1111;
				end
				`EBP_OCFG_HALF: begin
					lvl = {2'b00, dbl_b, dbl_a}; // R4
					own = 4'b0011;
				end
				default: begin
					lvl = {1'b0, 1'b1, mod_hi, 1'b0}; // R5
					own = 4'b1111;
				end
			endcase
		end
	end

	// Pins are registered so mode changes cannot glitch them
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pwm_a_o     <= 1'b0;
			pwm_b_o     <= 1'b0;
			pwm_c_o     <= 1'b0;
			pwm_d_o     <= 1'b0;
			pwm_own_a_o <= 1'b0;
			pwm_own_b_o <= 1'b0;
			pwm_own_c_o <= 1'b0;
			pwm_own_d_o <= 1'b0;
			pport_en_o  <= 1'b0;
		end else begin
			if (run_q) begin
				pwm_a_o <= lvl[0] ^ mode_a_q[`EBP_POL_AC]; // R17
				pwm_b_o <= lvl[1] ^ mode_a_q[`EBP_POL_BD];
				pwm_c_o <= lvl[2] ^ mode_a_q[`EBP_POL_AC];
				pwm_d_o <= lvl[3] ^ mode_a_q[`EBP_POL_BD];
			end else begin
				pwm_a_o <= 1'b0;
				pwm_b_o <= 1'b0;
				pwm_c_o <= 1'b0;
				pwm_d_o <= 1'b0;
			end
			// Direction of owned pins remains software's job
			pwm_own_a_o <= own[0];
			pwm_own_b_o <= own[1];
			pwm_own_c_o <= own[2];
			pwm_own_d_o <= own[3];
			pport_en_o  <= cfg_q[`EBP_CFG_PPORT] &
				~(run_q & (ocfg_a_q != `EBP_OCFG_SINGLE)); // R12
		end
	end

endmodule // ebp_pwm
`default_nettype wire

/* bench/ebp_pwm_assertions.sv */
// Checker for the PWM output stage, watching the top ports only.
// Assumes APB writes land at the access edge.
`timescale 1ns/1ps
`default_nettype none
`include "ebp_defs.vh"
module ebp_pwm_chk #(
	parameter DLY_W = 7
) (
	input wire logic        ref_clk_i,
	input wire logic        rst_b_i,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        pwm_a_o,
	input wire logic        pwm_b_o,
	input wire logic        pwm_c_o,
	input wire logic        pwm_d_o,
	input wire logic        pwm_own_a_o,
	input wire logic        pwm_own_b_o,
	input wire logic        pwm_own_c_o,
	input wire logic        pwm_own_d_o,
	input wire logic        pport_en_o
);
	logic [7:0] ctrl_q;
	logic       acc;
	logic       all_own;
	assign acc = psel && penable;
	assign all_own = pwm_own_a_o && pwm_own_b_o && pwm_own_c_o && pwm_own_d_o;
	// Shadow of the written control, not the active copy
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			ctrl_q <= 8'h00;
		else if (acc && pwrite && paddr == `EBP_OFS_CTRL)
			ctrl_q <= pwdata[7:0];
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	a_unmap_err: assert property (acc && paddr > 8'h14 |-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	a_map_noerr: assert property (acc && paddr[1:0] == 2'b00 && paddr <= 8'h14 |-> !pslverr)
		else $error("mapped access refused");
	a_nonpwm_own: assert property ((ctrl_q[3:2] != 2'b11) [*3] |-> !pwm_own_b_o && !pwm_own_c_o && !pwm_own_d_o)
		else $error("port pins held outside PWM");
	a_nonpwm_pins: assert property ((ctrl_q[3:2] != 2'b11) [*3] |-> pwm_own_a_o == (ctrl_q[3:0] != 4'h0))
		else $error("output A ownership wrong outside PWM");
	a_half_excl: assert property (pwm_own_a_o && pwm_own_b_o && !pwm_own_c_o && ctrl_q[1:0] == 2'b00 |-> !(pwm_a_o && pwm_b_o))
		else $error("half bridge outputs both active");
	a_fwd_bc: assert property (all_own && ctrl_q[1:0] == 2'b00 && pwm_a_o |-> !pwm_b_o && !pwm_c_o)
		else $error("forward bridge B or C active");
	a_rev_ad: assert property (all_own && ctrl_q[1:0] == 2'b00 && pwm_c_o |-> !pwm_a_o && !pwm_d_o)
		else $error("reverse bridge A or D active");
	a_pport_prio: assert property (pwm_own_b_o && $past(pwm_own_b_o) |-> !pport_en_o)
		else $error("parallel port enabled in bridge mode");
endmodule // ebp_pwm_chk
bind ebp_pwm ebp_pwm_chk #(.DLY_W(DLY_W)) i_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o),
	.pwm_c_o(pwm_c_o), .pwm_d_o(pwm_d_o), .pwm_own_a_o(pwm_own_a_o), .pwm_own_b_o(pwm_own_b_o),
	.pwm_own_c_o(pwm_own_c_o), .pwm_own_d_o(pwm_own_d_o), .pport_en_o(pport_en_o));
`default_nettype wire

/* bench/ebp_bridge_model.sv */
// Bridge power stage seen from the four PWM pins.
// Assumes active-high drive; flags any leg shorting.
`timescale 1ns/1ps
`default_nettype none
module ebp_bridge_model (
	input wire logic       ref_clk_i,
	input wire logic       rst_b_i,
	input wire logic [3:0] pin_i,
	input wire logic [3:0] own_i,
	output var logic       shoot_o
);
	logic [3:0] drv;
	// Unowned pins are port pins, ignored by the stage
	assign drv = pin_i & own_i;
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			shoot_o <= 1'b0;
		else if ((drv[0] && drv[1]) || (drv[2] && drv[3]))
			shoot_o <= 1'b1;
	end
endmodule // ebp_bridge_model
`default_nettype wire

/* bench/tb_top.sv */
// Testbench for the PWM output stage: APB tasks and pin counts.
// Assumes the checker is bound into the design.
`timescale 1ns/1ps
`default_nettype none
`include "ebp_defs.vh"
module tb_top;
	logic        ref_clk_i;
	logic        rst_b_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        pport_en_o;
	logic        shoot;
	logic [3:0]  pin;
	logic [3:0]  own;
	int          miscompares;
	int          checks;
	logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h0000_00FF, 32'h0};

	ebp_pwm i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm_a_o(pin[0]), .pwm_b_o(pin[1]), .pwm_c_o(pin[2]),
		.pwm_d_o(pin[3]), .pwm_own_a_o(own[0]), .pwm_own_b_o(own[1]), .pwm_own_c_o(own[2]),
		.pwm_own_d_o(own[3]), .pport_en_o(pport_en_o));
	ebp_bridge_model i_brg (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .pin_i(pin),
		.own_i(own), .shoot_o(shoot));

	task end_of_test;
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do begin
			@(posedge ref_clk_i);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	// Counts active samples over whole periods, so phase does not matter
	task run_case(input logic [7:0] per, dh, ct, input int ea, eb, ec, ed,
		input logic [3:0] eown, input logic epp);
		int cnt [4];
		int e [4];
		e = '{ea, eb, ec, ed};
		cnt = '{0, 0, 0, 0};
		// Timer held cleared while the period changes, so it cannot overrun a shorter one
		apb(`EBP_OFS_TMRCFG, 1'b1, 32'h0000_0008);
		apb(`EBP_OFS_PERIOD, 1'b1, {24'h0, per});
		apb(`EBP_OFS_DUTY, 1'b1, {24'h0, dh});
		apb(`EBP_OFS_CTRL, 1'b1, {24'h0, ct});
		apb(`EBP_OFS_TMRCFG, 1'b1, 32'h0000_000C);
		// Covers the first boundary, the longest period and dead-band settling
		repeat (40) @(posedge ref_clk_i);
		repeat (16) begin
			@(negedge ref_clk_i);
			for (int i = 0; i < 4; i++)
				cnt[i] += (pin[i] === 1'b1);
		end
		for (int i = 0; i < 4; i++)
			if (e[i] >= 0)
				chk(cnt[i], e[i], "pin_count");
		chk({28'h0, own}, {28'h0, eown}, "pin_own");
		chk({31'h0, pport_en_o}, {31'h0, epp}, "pport_en");
		@(posedge ref_clk_i);
	endtask

	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		miscompares++;
		end_of_test;
	end
	initial begin
		rst_b_i = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		@(posedge ref_clk_i);
		for (int i = 0; i < 5; i++) begin
			apb(ra[i], 1'b0, 32'h0);
			chk(rd, rv[i], "reset_value");
		end
		apb(8'h18, 1'b1, 32'h0000_00FF);
		chk({31'h0, err}, 32'h1, "unmapped_wr");
		apb(8'h18, 1'b0, 32'h0);
		chk(rd, 32'h0, "unmapped_rd");
		apb(`EBP_OFS_TMRCFG, 1'b1, 32'h0000_000C);
		run_case(8'h00, 8'h00, 8'h2C, 8, -1, -1, -1, 4'b0001, 1'b1);
		apb(`EBP_OFS_STATUS, 1'b0, 32'h0);
		chk({31'h0, rd[8]}, 32'h1, "status_run");
		apb(`EBP_OFS_CTRL, 1'b0, 32'h0);
		chk(rd, 32'h0000_002C, "ctrl_readback");
		run_case(8'h00, 8'h01, 8'h0C, 16, -1, -1, -1, 4'b0001, 1'b1);
		run_case(8'h01, 8'h00, 8'h2C, 4, -1, -1, -1, 4'b0001, 1'b1);
		run_case(8'h00, 8'h00, 8'h1E, 12, -1, -1, -1, 4'b0001, 1'b1);
		run_case(8'h00, 8'h00, 8'h6C, 16, 0, 0, 8, 4'b1111, 1'b0);
		run_case(8'h00, 8'h00, 8'hEC, 0, 8, 16, 0, 4'b1111, 1'b0);
		apb(`EBP_OFS_DBAND, 1'b1, 32'h0000_0001);
		apb(`EBP_OFS_DBAND, 1'b0, 32'h0);
		chk(rd, 32'h0000_0001, "dband_readback");
		// Duty 8 of a 16-clock period, less 4 clocks of dead band on each leg
		run_case(8'h03, 8'h02, 8'h8C, 4, 4, -1, -1, 4'b0011, 1'b0);
		run_case(8'h00, 8'h00, 8'h04, 0, -1, -1, -1, 4'b0001, 1'b1);
		chk({31'h0, shoot}, 32'h0, "shoot_through");
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire
